// File: pkg/tmc_params.svh
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH
// =============================================
// RF command codes
`define TMC_JIS_READ   8'h06
`define TMC_B_READ     8'hb0
`define TMC_JIS_WRITE  8'h08
`define TMC_B_WRITE    8'hd6
// =============================================
// Host command codes
`define TMC_INQUIRY    8'h28
`define TMC_RES_OK     8'hf8
`define TMC_RES_ERR    8'he8
// =============================================
// Read command layout and field ranges
`define TMC_ID_LEN     8'h08
`define TMC_K_IDX      8'h09
`define TMC_SID_IDX    8'h0a
`define TMC_B_INS_IDX  8'h01
`define TMC_CNT_MIN    8'h01
`define TMC_CNT_MAX    8'h0f
`endif

// File: pkg/tmc_pkg.sv
package tmc_pkg;
    // Supervisor states, Gray along the usual path
    typedef enum logic [2:0] {
        TMC_IDLE  = 3'h0,
        TMC_PARSE = 3'h1,
        TMC_WINQ  = 3'h3,
        TMC_WRES  = 3'h2
    } tmc_state_t;

    // Byte arriving from the RF framer
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } tmc_rf_byte_t;

    // Events handed back to the surrounding logic
    typedef struct packed {
        logic tunnel_req;
        logic rf_err;
        logic res_ok;
        logic res_err;
        logic timeout;
    } tmc_evt_t;
endpackage

// File: core/tmc_core.sv
// Overview of operation
// R1: In tunnel mode, abandon the exchange when inquiry or result wait times out.
// R2: Host command timing starts at the ack of its own slave address.
// R3: Inquiry timer starts when interrupt falls; timeout at inquiry wait limit.
// R4: Another host command pauses the wait timer until its reply is sent.
// R5: Result timer starts right after the first reply to a valid inquiry.
// R6: Result wait expiry answers the pending RF command with an error.
// R7: RF read code is 0x06 (JIS) or instruction 0xB0 (Type B).
// R8: RF write code is 0x08 (JIS) or instruction 0xD6 (Type B).
// R9: Host byte 0x28 is the inquiry command.
// R10: Host byte 0xF8 is a normal-end result.
// R11: Host byte 0xE8 is an error result.
// R12: JIS read carries the 8-byte card identifier after the code.
// R13: Service-file count must be 1 to 15, else error response.
// R14: Service-file identifiers ignored, but listed ones must all match.
// R15: Block count must be 1 to 15, else error response.
// R16: Inquiry wait limit comes from a non-volatile system parameter.
// R17: Host commands are accepted from the interrupt falling edge onward.
// R18: Interrupt released when own address is seen in a host read request.
// R19: Timers tick on the timebase, clear per exchange, stop on arrival.
`include "tmc_params.svh"

module tmc_core #(
    parameter int TW = 16                    // Wait counter width
) (
    input  wire logic                  mclk_i,       // System clock
    input  wire logic                  rst_i,        // Sync reset, high
    input  wire logic                  tunnel_i,     // Tunnel mode active
    input  wire logic                  typeb_i,      // RF uses Type B
    input  wire tmc_pkg::tmc_rf_byte_t rf_i,         // RF command bytes
    input  wire logic                  tick_i,       // Timebase enable
    input  wire logic [TW-1:0]         inq_limit_i,  // Inquiry wait limit
    input  wire logic [TW-1:0]         res_limit_i,  // Result wait limit
    input  wire logic                  addr_ack_i,   // Own address ack starts
    input  wire logic                  addr_rd_i,    // Request is a read
    input  wire logic                  cmd_valid_i,  // Host command byte
    input  wire logic [7:0]            cmd_i,        // Host command code
    input  wire logic                  reply_done_i, // Reply to host sent
    output logic                       host_interrupt_n_o, // Interrupt, low
    output logic                       cmd_ready_o,  // Host cmds accepted
    output logic                       rf_write_o,   // Pending is a write
    output tmc_pkg::tmc_evt_t          evt_o         // One-cycle events
);

    // =============================================
    // State
    tmc_pkg::tmc_state_t state_reg, state_next;
    logic [7:0]          idx_reg, idx_next;
    logic [7:0]          k_reg, k_next;
    logic [15:0]         sid_reg, sid_next;
    logic                bad_reg, bad_next;
    logic                rd_reg, rd_next;
    logic                wr_reg, wr_next;
    logic [TW-1:0]       cnt_reg, cnt_next;
    logic                pause_reg, pause_next;
    logic                inq_reg, inq_next;
    logic                irqn_next;
    logic                rdy_next;
    tmc_pkg::tmc_evt_t   evt_next;

    // Count field check shared by both count fields
    function automatic logic cnt_ok(input logic [7:0] v);
        cnt_ok = (v >= `TMC_CNT_MIN) && (v <= `TMC_CNT_MAX); // R13 R15
    endfunction

    // Timer expiry and arrival decodes
    logic [TW-1:0] limit;
    logic          tmo_hit;
    logic          is_inq;
    logic          is_res;
    logic [7:0]    sid_pos;
    assign limit   = (state_reg == tmc_pkg::TMC_WRES) ? res_limit_i
                                                      : inq_limit_i;
    assign tmo_hit = (cnt_reg >= limit) && !pause_reg && !inq_reg;
    assign is_inq  = cmd_valid_i && (cmd_i == `TMC_INQUIRY);    // R9
    assign is_res  = cmd_valid_i && ((cmd_i == `TMC_RES_OK) ||
                                     (cmd_i == `TMC_RES_ERR));
    assign sid_pos = idx_reg - `TMC_SID_IDX;

    // =============================================
    // Next-state logic
    always_comb begin
        state_next = state_reg;
        idx_next   = idx_reg;
        k_next     = k_reg;
        sid_next   = sid_reg;
        bad_next   = bad_reg;
        rd_next    = rd_reg;
        wr_next    = wr_reg;
        cnt_next   = cnt_reg;
        pause_next = pause_reg;
        inq_next   = inq_reg;
        irqn_next  = host_interrupt_n_o;
        rdy_next   = cmd_ready_o;
        evt_next   = '0;

        // Command window from address ack to its reply; a new ack in
        // the cycle the last reply ends keeps the timer paused
        if (reply_done_i) begin
            pause_next = 1'b0;                                  // R4
        end
        if (addr_ack_i) begin
            pause_next = 1'b1;                                  // R2 R4
        end

        case (state_reg)
            tmc_pkg::TMC_IDLE: begin
                if (tunnel_i && rf_i.valid && rf_i.sof) begin
                    state_next = tmc_pkg::TMC_PARSE;
                    idx_next   = 8'h01;
                    bad_next   = 1'b0;
                    rd_next    = !typeb_i &&
                                 (rf_i.data == `TMC_JIS_READ);  // R7
                    wr_next    = !typeb_i &&
                                 (rf_i.data == `TMC_JIS_WRITE); // R8
                end
            end
            tmc_pkg::TMC_PARSE: begin
                if (rf_i.valid) begin
                    idx_next = idx_reg + 8'h01;
                    // Type B instruction sits after the class byte
                    if (typeb_i && idx_reg == `TMC_B_INS_IDX) begin
                        rd_next = (rf_i.data == `TMC_B_READ);   // R7
                        wr_next = (rf_i.data == `TMC_B_WRITE);  // R8
                    end
                    // JIS read: identifier skipped, then fields
                    if (!typeb_i && rd_reg) begin               // R12
                        if (idx_reg == `TMC_K_IDX) begin
                            k_next = rf_i.data;
                            if (!cnt_ok(rf_i.data)) begin
                                bad_next = 1'b1;                // R13
                            end
                        end else if (idx_reg >= `TMC_SID_IDX &&
                                     sid_pos < {k_reg[6:0], 1'b0}) begin
                            if (sid_pos < 8'h02) begin
                                if (sid_pos[0]) begin
                                    sid_next[7:0] = rf_i.data;
                                end else begin
                                    sid_next[15:8] = rf_i.data;
                                end
                            end else if (rf_i.data != (sid_pos[0] ?
                                         sid_reg[7:0] : sid_reg[15:8])
                                        ) begin
                                bad_next = 1'b1;                // R14
                            end
                        end else if (idx_reg >= `TMC_SID_IDX &&
                                     sid_pos == {k_reg[6:0], 1'b0} &&
                                     !cnt_ok(rf_i.data)) begin
                            bad_next = 1'b1;                    // R15
                        end
                    end
                end
                if (rf_i.valid && rf_i.eof) begin
                    if (!(rd_reg || wr_reg)) begin
                        state_next = tmc_pkg::TMC_IDLE;
                    end else if (bad_next) begin
                        state_next      = tmc_pkg::TMC_IDLE;
                        evt_next.rf_err = 1'b1;             // R13 R14 R15
                    end else begin
                        // New exchange: raise interrupt, clear timer
                        state_next          = tmc_pkg::TMC_WINQ;
                        evt_next.tunnel_req = 1'b1;
                        irqn_next           = 1'b0;             // R3
                        rdy_next            = 1'b1;             // R17
                        cnt_next            = '0;               // R19
                        pause_next          = 1'b0;
                        inq_next            = 1'b0;
                    end
                end
            end
            tmc_pkg::TMC_WINQ: begin
                if (is_inq) begin
                    inq_next = 1'b1;                            // R19
                end
                if (inq_reg && reply_done_i) begin
                    state_next = tmc_pkg::TMC_WRES;             // R5
                    cnt_next   = '0;
                    inq_next   = 1'b0;
                end else if (tmo_hit && !is_inq) begin
                    state_next       = tmc_pkg::TMC_IDLE;       // R1 R3
                    evt_next.timeout = 1'b1;
                end else if (tick_i && !pause_reg && !inq_reg) begin
                    cnt_next = cnt_reg + 1'b1;                  // R4 R16
                end
            end
            tmc_pkg::TMC_WRES: begin
                if (is_res) begin
                    state_next       = tmc_pkg::TMC_IDLE;       // R19
                    evt_next.res_ok  = (cmd_i == `TMC_RES_OK);  // R10
                    evt_next.res_err = (cmd_i == `TMC_RES_ERR); // R11
                end else if (tmo_hit) begin
                    state_next       = tmc_pkg::TMC_IDLE;       // R1
                    evt_next.timeout = 1'b1;
                    evt_next.rf_err  = 1'b1;                    // R6
                end else if (tick_i && !pause_reg) begin
                    cnt_next = cnt_reg + 1'b1;                  // R4
                end
            end
            default: begin
                state_next = tmc_pkg::TMC_IDLE;
            end
        endcase

        // Leaving tunnel mode drops the exchange
        if (!tunnel_i) begin
            state_next = tmc_pkg::TMC_IDLE;
        end
        if (state_next == tmc_pkg::TMC_IDLE) begin
            rdy_next = 1'b0;
        end
        // Own address in a read request releases the interrupt
        if (addr_ack_i && addr_rd_i) begin
            irqn_next = 1'b1;                                   // R18
        end
    end

    // =============================================
    // Registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_reg          <= tmc_pkg::TMC_IDLE;
            idx_reg            <= 8'h00;
            k_reg              <= 8'h00;
            sid_reg            <= 16'h0000;
            bad_reg            <= 1'b0;
            rd_reg             <= 1'b0;
            wr_reg             <= 1'b0;
            cnt_reg            <= '0;
            pause_reg          <= 1'b0;
            inq_reg            <= 1'b0;
            host_interrupt_n_o <= 1'b1;
            cmd_ready_o        <= 1'b0;
            rf_write_o         <= 1'b0;
            evt_o              <= '0;
        end else begin
            state_reg          <= state_next;
            idx_reg            <= idx_next;
            k_reg              <= k_next;
            sid_reg            <= sid_next;
            bad_reg            <= bad_next;
            rd_reg             <= rd_next;
            wr_reg             <= wr_next;
            cnt_reg            <= cnt_next;
            pause_reg          <= pause_next;
            inq_reg            <= inq_next;
            host_interrupt_n_o <= irqn_next;
            cmd_ready_o        <= rdy_next;
            rf_write_o         <= wr_next;
            evt_o              <= evt_next;
        end
    end

    // =============================================
    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // Interrupt fall opens the inquiry wait with a cleared timer
    a_irq_fall_start: assert property ( // R3
        $fell(host_interrupt_n_o) |->
            state_reg == tmc_pkg::TMC_WINQ && cnt_reg == '0 && cmd_ready_o)
        else $error("interrupt fell without a fresh inquiry wait");

    // Read request with own address releases the interrupt
    a_irq_release: assert property ( // R18
        addr_ack_i && addr_rd_i |=> host_interrupt_n_o)
        else $error("interrupt not released on read address");

    // Inquiry wait expiry abandons the exchange
    a_inq_timeout: assert property ( // R1
        tunnel_i && state_reg == tmc_pkg::TMC_WINQ && tmo_hit && !is_inq
            && !(inq_reg && reply_done_i)
        |=> evt_o.timeout && !evt_o.rf_err &&
            state_reg == tmc_pkg::TMC_IDLE)
        else $error("inquiry timeout not taken");

    // Result timer frozen while another host command is open
    a_pause_hold: assert property ( // R4
        pause_reg && !reply_done_i && state_reg == tmc_pkg::TMC_WRES
            && $stable(state_reg)
        |=> state_reg != tmc_pkg::TMC_WRES || cnt_reg == $past(cnt_reg))
        else $error("wait timer moved during a paused command");

    // Reply to the inquiry starts the result timer at zero
    a_res_start: assert property ( // R5
        tunnel_i && state_reg == tmc_pkg::TMC_WINQ && inq_reg &&
            reply_done_i
        |=> state_reg == tmc_pkg::TMC_WRES && cnt_reg == '0)
        else $error("result wait not started after inquiry reply");

    // Result wait expiry gives an RF error answer
    a_res_error: assert property ( // R6
        tunnel_i && state_reg == tmc_pkg::TMC_WRES && tmo_hit && !is_res
        |=> evt_o.rf_err && evt_o.timeout)
        else $error("no RF error after result timeout");

    // Normal-end result decode
    a_res_ok: assert property ( // R10
        tunnel_i && state_reg == tmc_pkg::TMC_WRES && cmd_valid_i &&
            cmd_i == 8'hf8
        |=> evt_o.res_ok && !evt_o.res_err)
        else $error("normal-end result not decoded");

    // Error result decode
    a_res_err: assert property ( // R11
        tunnel_i && state_reg == tmc_pkg::TMC_WRES && cmd_valid_i &&
            cmd_i == 8'he8
        |=> evt_o.res_err && !evt_o.res_ok)
        else $error("error result not decoded");

    // Result timer stops once the result arrives
    a_stop_arrive: assert property ( // R19
        evt_o.res_ok || evt_o.res_err |-> state_reg == tmc_pkg::TMC_IDLE
            && !evt_o.timeout)
        else $error("timer kept running after result");

endmodule

// File: tb/tmc_host_model.sv
module tmc_host_model (
    input  wire logic       mclk_i,       // System clock
    output logic            addr_ack_o,   // Own address ack starts
    output logic            addr_rd_o,    // Read direction request
    output logic            cmd_valid_o,  // Command byte valid
    output logic [7:0]      cmd_o,        // Command code
    output logic            reply_done_o  // Reply to host finished
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================
    // Idle bus
    initial begin
        addr_ack_o   = 1'b0;
        addr_rd_o    = 1'b0;
        cmd_valid_o  = 1'b0;
        cmd_o        = 8'h00;
        reply_done_o = 1'b0;
    end

    // Read-direction request, which releases the interrupt
    task automatic read_req();
        @(posedge mclk_i);
        addr_ack_o <= 1'b1;
        addr_rd_o  <= 1'b1;
        @(posedge mclk_i);
        addr_ack_o <= 1'b0;
        addr_rd_o  <= 1'b0;
    endtask

    // Command byte framed by address ack and a reply gap cycles later
    task automatic command(input logic [7:0] code, input int gap);
        @(posedge mclk_i);
        addr_ack_o  <= 1'b1;
        @(posedge mclk_i);
        addr_ack_o  <= 1'b0;
        cmd_valid_o <= 1'b1;
        cmd_o       <= code;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        cmd_o       <= ~code; // Stale byte must not look valid
        repeat (gap) @(posedge mclk_i);
        reply_done_o <= 1'b1;
        @(posedge mclk_i);
        reply_done_o <= 1'b0;
    endtask
endmodule

// File: tb/tunnel_mode_command_timeout_test.sv
`include "tmc_params.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
    $display("wrong value at %0t: compare failed", $time); \
    err_count++; end end

module tunnel_mode_command_timeout_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================
    // Stimulus and observation
    logic                  mclk_i   = 1'b0;
    logic                  rst_i    = 1'b1;
    logic                  tunnel_i = 1'b1;
    logic                  typeb_i  = 1'b0;
    logic                  tick_i   = 1'b0;
    logic                  clr      = 1'b0;
    tmc_pkg::tmc_rf_byte_t rf_i     = '0;
    logic [15:0]           inq_lim  = 16'h0008;
    logic [15:0]           res_lim  = 16'h0008;
    logic                  ack;
    logic                  rd;
    logic                  cv;
    logic                  done;
    logic [7:0]            cmd;
    logic                  host_interrupt_n_o;
    logic                  cmd_ready_o;
    logic                  rf_write_o;
    tmc_pkg::tmc_evt_t     evt_o;
    tmc_pkg::tmc_evt_t     seen     = '0;
    int                    err_count = 0;
    int                    n_tests   = 0;
    int                    n;
    logic [31:0]           seed     = 32'd26898;

    tmc_core #(.TW(16)) u_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .tunnel_i(tunnel_i),
        .typeb_i(typeb_i), .rf_i(rf_i), .tick_i(tick_i),
        .inq_limit_i(inq_lim), .res_limit_i(res_lim), .addr_ack_i(ack),
        .addr_rd_i(rd), .cmd_valid_i(cv), .cmd_i(cmd),
        .reply_done_i(done), .host_interrupt_n_o(host_interrupt_n_o),
        .cmd_ready_o(cmd_ready_o), .rf_write_o(rf_write_o), .evt_o(evt_o));

    tmc_host_model u_host (
        .mclk_i(mclk_i), .addr_ack_o(ack), .addr_rd_o(rd),
        .cmd_valid_o(cv), .cmd_o(cmd), .reply_done_o(done));

    // Clock and sticky record of event pulses
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) seen <= clr ? '0 : (seen | evt_o);

    // ==================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Read is accepted only for counts 1..15 and matching service ids
    function automatic logic rd_ok(input logic [7:0] k, m, input logic bad);
        return k >= 8'h01 && k <= 8'h0f && m >= 8'h01 && m <= 8'h0f
            && !(bad && k > 8'h01);
    endfunction

    task automatic send_frame(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge mclk_i);
            rf_i <= '{1'b1, i == 0, i == b.size() - 1, b[i]};
        end
        @(posedge mclk_i);
        rf_i <= '{1'b0, 1'b0, 1'b0, ~b[b.size() - 1]};
    endtask

    // Frame: code, 8-byte identifier, k, service ids, m, block list
    task automatic rf_jis(input logic [7:0] c, k, m, input logic bad);
        logic [7:0] q[$];
        q = {c, 8'h01, 8'h02, 8'h03, 8'h04,
             8'h05, 8'h06, 8'h07, 8'h08, k};
        for (int j = 0; j < k; j++) begin
            q.push_back((bad && j == k - 1) ? 8'h0a : 8'h09);
            q.push_back(8'h00);
        end
        q = {q, m, 8'h80, 8'h00};
        send_frame(q);
    endtask

    task automatic wait_evt(input int bitn, output int cnt);
        cnt = 0;
        do begin
            @(negedge mclk_i);
            cnt++;
        end while (evt_o[bitn] !== 1'b1 && cnt < 400);
    endtask

    task automatic end_winq();
        `CHK(host_interrupt_n_o, 1'b0)
        `CHK(cmd_ready_o, 1'b1)
        u_host.read_req();
        @(negedge mclk_i);
        `CHK(host_interrupt_n_o, 1'b1)
        u_host.command(8'h00, 0);
        wait_evt(0, n);
        `CHK(evt_o.timeout, 1'b1)
    endtask

    task automatic chk_read(input logic [7:0] k, m, input logic bad);
        logic ok;
        ok = rd_ok(k, m, bad);
        rf_jis(`TMC_JIS_READ, k, m, bad);
        @(negedge mclk_i);
        `CHK(evt_o.tunnel_req, ok)
        `CHK(evt_o.rf_err, !ok)
        if (ok) end_winq();
    endtask

    // Inquiry then a result, or no result when bitn is zero
    task automatic exch(input logic [7:0] res, input int bitn);
        clr <= 1'b1;
        rf_jis(`TMC_JIS_READ, 8'h02, 8'h03, 1'b0);
        clr <= 1'b0;
        @(negedge mclk_i);
        `CHK(evt_o.tunnel_req, 1'b1)
        u_host.read_req();
        u_host.command(`TMC_RES_OK, 0);
        @(negedge mclk_i);
        `CHK(seen.res_ok, 1'b0)
        u_host.command(`TMC_INQUIRY, 2);
        fork
            if (bitn != 0) u_host.command(res, 0);
            wait_evt(bitn, n);
        join
        `CHK(n <= (bitn ? 8 : 34) && n >= (bitn ? 1 : 28), 1'b1)
        @(negedge mclk_i);
        `CHK(seen.rf_err, bitn == 0)
        `CHK(cmd_ready_o, 1'b0)
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==================================================
    // Main sequence
    initial begin
        static logic [7:0] ck[7] = '{8'h01, 8'h0f, 8'h10, 8'h01, 8'h00,
                                     8'h01, 8'h03};
        static logic [7:0] cm[7] = '{8'h01, 8'h0f, 8'h01, 8'h10, 8'h01,
                                     8'h00, 8'h02};
        repeat (3) @(posedge mclk_i);
        rst_i  <= 1'b0;
        tick_i <= 1'b1;
        for (int c = 0; c < 7; c++) chk_read(ck[c], cm[c], c == 6);
        for (int r = 0; r < 24; r++)
            chk_read(8'(rnd() % 17), 8'(rnd() % 17), rnd() % 3 == 0);
        // JIS write code and the Type B read and write codes
        for (int w = 0; w < 3; w++) begin
            typeb_i <= w > 0;
            if (w == 0) rf_jis(`TMC_JIS_WRITE, 8'h01, 8'h01, 1'b0);
            else send_frame({8'h00, (w == 1) ? `TMC_B_READ : `TMC_B_WRITE,
                             8'h00, 8'h00, 8'h10});
            @(negedge mclk_i);
            `CHK(rf_write_o, w != 1)
            end_winq();
        end
        typeb_i <= 1'b0;
        // Inquiry wait, plain and paused by another command
        inq_lim <= 16'd40;
        for (int p = 0; p < 2; p++) begin
            rf_jis(`TMC_JIS_READ, 8'h01, 8'h01, 1'b0);
            @(negedge mclk_i);
            fork
                if (p != 0) u_host.command(8'h00, 30);
                wait_evt(0, n);
            join
            `CHK(n >= 39 + 30 * p && n <= 43 + 36 * p, 1'b1)
            u_host.read_req();
            u_host.command(8'h00, 0);
        end
        res_lim <= 16'd30;
        exch(`TMC_RES_OK, 2);
        exch(`TMC_RES_ERR, 1);
        exch(8'h00, 0);
        summarize();
    end

    // Watchdog
    initial begin
        #300us;
        err_count++;
        summarize();
    end
endmodule
